/* inc/crf_consts.svh */
// Constants for the CPU register file and condition-code flags.
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH
`define CRF_BIT_MASK 3'd7
`define CRF_BIT_UMASK 3'd6
`define CRF_BIT_HALF 3'd5
`define CRF_BIT_USER 3'd4
`define CRF_BIT_NEG 3'd3
`define CRF_BIT_ZERO 3'd2
`define CRF_BIT_OVF 3'd1
`define CRF_BIT_CARRY 3'd0
`define CRF_SP_INDEX 3'd7
`define CRF_ADDR_1M_MASK 24'h0fffff
`define CRF_ADDR_16M_MASK 24'hffffff
`define CRF_PC_ALIGN_MASK 24'hfffffe
`define CRF_HC_BYTE 5'd3
`define CRF_HC_WORD 5'd11
`define CRF_HC_LONG 5'd27
`define CRF_MSB_BYTE 5'd7
`define CRF_MSB_WORD 5'd15
`define CRF_MSB_LONG 5'd31
`define CRF_FLAGS_RESET 8'h80
`endif

/* inc/crf_pkg.sv */
// Types shared by the CPU register file and condition-code flags.
package crf_pkg;
    typedef enum logic [1:0] {
        CRF_SZ_BYTE = 2'b00,
        CRF_SZ_WORD = 2'b01,
        CRF_SZ_LONG = 2'b10
    } crf_size_t;
    // Which part of a full word register a narrow access selects.
    typedef enum logic [1:0] {
        CRF_PART_BOTTOM = 2'b00,
        CRF_PART_TOP = 2'b01,
        CRF_PART_EXT = 2'b10
    } crf_part_t;
    typedef enum logic [2:0] {
        CRF_FOP_NONE = 3'b000,
        CRF_FOP_LOAD = 3'b001,
        CRF_FOP_AND = 3'b010,
        CRF_FOP_OR = 3'b011,
        CRF_FOP_XOR = 3'b100
    } crf_fop_t;
    typedef enum logic [1:0] {
        CRF_ST_RESET = 2'b00,
        CRF_ST_VECTOR = 2'b01,
        CRF_ST_RUN = 2'b10
    } crf_state_t;
    typedef struct packed {
        logic en;
        logic [2:0] idx;
        crf_size_t size;
        crf_part_t part;
        logic [31:0] data;
    } crf_wr_t;
    // Arithmetic operands presented for flag update.
    typedef struct packed {
        logic arith;
        logic sub;
        crf_size_t size;
        logic [31:0] a;
        logic [31:0] b;
        logic upd_half;
        logic upd_neg;
        logic upd_zero;
        logic upd_ovf;
        logic upd_carry;
    } crf_alu_t;
    // Flag update for non-arithmetic results: logic, shifts, bit ops.
    typedef struct packed {
        logic en;
        crf_size_t size;
        logic [31:0] res;
        logic upd_nz;
        logic clr_v;
        logic upd_carry;
        logic carry_val;
    } crf_misc_t;
endpackage : crf_pkg

/* testbench/crf_testbench.sv */
// Self-checking testbench for the CPU register file and condition flags.
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.svh"
module testbench;
    import crf_pkg::*;
    logic sys_clk, arst_n, mode_1m, vector_valid, sp_wr_en, pc_wr_en;
    logic exc_start, irq_req, nmi_req, use_umask, irq_accept, ready;
    logic [23:0] reset_vector, pc_wr_data, ea_in, fetch_addr, pc_out, ea_out;
    logic [31:0] sp_wr_data, rd_data, sp_out;
    logic [2:0] rd_idx;
    logic [7:0] flags_imm, condition_code_flags, fl;
    crf_size_t rd_size;
    crf_part_t rd_part;
    crf_fop_t flags_op;
    crf_wr_t reg_wr;
    crf_alu_t alu_in;
    crf_misc_t misc_in;
    logic [31:0] mdl [8];
    int bad_count, comparisons;
    crf_core DUT (.sys_clk, .arst_n, .mode_1m, .reset_vector, .vector_valid,
        .reg_wr, .rd_idx, .rd_size, .rd_part, .sp_wr_en, .sp_wr_data,
        .pc_wr_en, .pc_wr_data, .ea_in, .flags_op, .flags_imm, .alu_in,
        .misc_in, .exc_start, .irq_req, .nmi_req, .use_umask, .rd_data,
        .sp_out, .fetch_addr, .pc_out, .ea_out, .condition_code_flags,
        .irq_accept, .ready);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] msk(crf_size_t s);
        return s == CRF_SZ_BYTE ? 32'h000000ff :
            s == CRF_SZ_WORD ? 32'h0000ffff : 32'hffffffff;
    endfunction : msk
    function automatic crf_part_t pp(crf_size_t s, logic r);
        if (s == CRF_SZ_LONG || !r) return CRF_PART_BOTTOM;
        return s == CRF_SZ_WORD ? CRF_PART_EXT : CRF_PART_TOP;
    endfunction : pp
    function automatic logic [31:0] view(logic [31:0] v, crf_size_t s,
            crf_part_t p);
        if (s == CRF_SZ_LONG) return v;
        if (s == CRF_SZ_WORD) return p == CRF_PART_EXT ? v >> 16 : v & msk(s);
        return p == CRF_PART_TOP ? (v >> 8) & msk(s) : v & msk(s);
    endfunction : view
    function automatic logic [31:0] merge(logic [31:0] v, logic [31:0] d,
            crf_size_t s, crf_part_t p);
        int sh;
        sh = (p == CRF_PART_EXT) ? 16 : (p == CRF_PART_TOP) ? 8 : 0;
        return (v & ~(msk(s) << sh)) | ((d & msk(s)) << sh);
    endfunction : merge
    // Half carry is taken from the low slice so the bit above it is the carry.
    function automatic logic [7:0] alu_flags(logic [7:0] f, logic sub,
            crf_size_t s, logic [31:0] a, logic [31:0] b);
        int w;
        logic [32:0] r, hs, hm;
        w = s == CRF_SZ_BYTE ? 8 : s == CRF_SZ_WORD ? 16 : 32;
        hm = (33'h1 << (w - 4)) - 33'h1;
        r = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        hs = sub ? ({1'b0, a} & hm) - ({1'b0, b} & hm) :
            ({1'b0, a} & hm) + ({1'b0, b} & hm);
        f[5] = hs[w-4];
        f[3] = r[w-1];
        f[2] = (r[31:0] & msk(s)) == 32'h0;
        f[1] = (a[w-1] ^ b[w-1] ^ !sub) && (r[w-1] != a[w-1]);
        f[0] = r[w];
        return f;
    endfunction : alu_flags
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg,
                got, exp);
        end
    endtask : chk
    task automatic done(string t);
        $display("Test %s finished", t);
    endtask : done
    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons,
            bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic wreg(logic [2:0] i, crf_size_t s, crf_part_t p,
            logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= '{1'b1, i, s, p, d};
        mdl[i] = merge(mdl[i], d, s, p);
        @(posedge sys_clk);
        reg_wr.en <= 1'b0;
    endtask : wreg
    task automatic rreg(logic [2:0] i, crf_size_t s, crf_part_t p);
        @(posedge sys_clk);
        rd_idx <= i;
        rd_size <= s;
        rd_part <= p;
        @(posedge sys_clk);
        #1;
        chk(rd_data, view(mdl[i], s, p), "register read");
    endtask : rreg
    // The flag pulse is dropped at the edge that takes it, then checked.
    task automatic fop(crf_fop_t op, logic [7:0] imm);
        @(posedge sys_clk);
        flags_op <= op;
        flags_imm <= imm;
        fl = op == CRF_FOP_LOAD ? imm : op == CRF_FOP_AND ? fl & imm :
            op == CRF_FOP_OR ? fl | imm : fl ^ imm;
        @(posedge sys_clk);
        flags_op <= CRF_FOP_NONE;
        #1;
        chk(condition_code_flags, fl, "flag operation");
    endtask : fop
    task automatic alu(logic sub, crf_size_t s, logic [31:0] a,
            logic [31:0] b, logic u);
        @(posedge sys_clk);
        alu_in <= '{1'b1, sub, s, a, b, u, u, u, u, u};
        if (u) fl = alu_flags(fl, sub, s, a, b);
        @(posedge sys_clk);
        alu_in.arith <= 1'b0;
        #1;
        chk(condition_code_flags, fl, "arithmetic flags");
    endtask : alu
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        int n, k;
        logic [31:0] d, a, b, m;
        logic [23:0] vec, pv, ev;
        crf_size_t s;
        logic md;
        {arst_n, mode_1m, vector_valid, sp_wr_en, pc_wr_en} = 5'h00;
        {exc_start, irq_req, nmi_req, use_umask} = 4'h0;
        {reset_vector, pc_wr_data, ea_in, sp_wr_data} = '0;
        {rd_idx, flags_imm, reg_wr, alu_in, misc_in} = '0;
        rd_size = CRF_SZ_LONG;
        rd_part = CRF_PART_BOTTOM;
        flags_op = CRF_FOP_NONE;
        bad_count = 0;
        comparisons = 0;
        void'($urandom(29878));
        repeat (20) @(posedge sys_clk);
        #1;
        chk(condition_code_flags[7], 1'b1, "mask held in reset");
        chk(ready, 1'b0, "ready held in reset");
        vec = 24'($urandom) | 24'h000001;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        reset_vector <= vec;
        pc_wr_en <= 1'b1;
        pc_wr_data <= ~vec;
        repeat (3) @(posedge sys_clk);
        vector_valid <= 1'b1;
        pc_wr_en <= 1'b0;
        // Sample after the edge so the flop that rises there has settled.
        for (n = 0; n < 20 && ready !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 20) begin
            bad_count++;
            $display("MISMATCH at %0t: ready never rose", $time);
            wrap_up();
        end
        #1;
        chk(pc_out, vec, "pc from vector");
        chk(fetch_addr, vec & `CRF_PC_ALIGN_MASK, "fetch aligned");
        chk(condition_code_flags[7], 1'b1, "mask after reset");
        done("reset");
        for (n = 0; n < 8; n++) begin
            wreg(n[2:0], CRF_SZ_LONG, CRF_PART_BOTTOM, $urandom);
        end
        for (n = 0; n < 8; n++) begin
            rreg(n[2:0], CRF_SZ_LONG, CRF_PART_BOTTOM);
        end
        for (n = 0; n < 60; n++) begin
            s = crf_size_t'(2'($urandom_range(2)));
            k = $urandom_range(7);
            wreg(k[2:0], s, pp(s, 1'($urandom)), $urandom);
            s = crf_size_t'(2'($urandom_range(2)));
            rreg(3'($urandom), s, pp(s, 1'($urandom)));
            rreg(k[2:0], CRF_SZ_LONG, CRF_PART_BOTTOM);
        end
        done("registers");
        for (n = 0; n < 2; n++) begin
            d = $urandom;
            @(posedge sys_clk);
            sp_wr_en <= 1'b1;
            sp_wr_data <= n == 0 ? ~d : d;
            reg_wr <= '{n == 0, 3'h7, CRF_SZ_LONG, CRF_PART_BOTTOM, d};
            mdl[7] = d;
            @(posedge sys_clk);
            sp_wr_en <= 1'b0;
            reg_wr.en <= 1'b0;
            @(posedge sys_clk);
            #1;
            chk(sp_out, d, "stack pointer");
            rreg(3'h7, CRF_SZ_LONG, CRF_PART_BOTTOM);
        end
        done("stack pointer");
        for (n = 0; n < 20; n++) begin
            md = n[0];
            pv = 24'($urandom);
            ev = 24'($urandom);
            m = md ? `CRF_ADDR_1M_MASK : `CRF_ADDR_16M_MASK;
            @(posedge sys_clk);
            mode_1m <= md;
            pc_wr_en <= 1'b1;
            pc_wr_data <= pv;
            ea_in <= ev;
            @(posedge sys_clk);
            pc_wr_en <= 1'b0;
            @(posedge sys_clk);
            #1;
            chk(pc_out, pv, "pc load");
            chk(fetch_addr, pv & m & `CRF_PC_ALIGN_MASK, "fetch");
            chk(ea_out, ev & m, "effective address");
        end
        done("addresses");
        fop(CRF_FOP_LOAD, 8'h00);
        for (n = 1; n <= 4; n++) fop(crf_fop_t'(n[2:0]), 8'($urandom));
        for (n = 0; n < 20; n++) begin
            fop(crf_fop_t'(3'($urandom_range(4, 1))), 8'($urandom));
        end
        done("flag operations");
        for (n = 0; n < 48; n++) begin
            s = crf_size_t'(2'(n % 3));
            m = msk(s);
            a = n < 12 ? m >> (n / 3 % 2) : $urandom & m;
            b = n < 6 ? 32'h1 : n < 12 ? a : $urandom & m;
            if (n % 12 == 9) a = 32'h0;
            alu(n[0], s, a, b, n % 7 != 6);
        end
        done("arithmetic");
        for (n = 0; n < 16; n++) begin
            s = crf_size_t'(2'(n % 3));
            d = n < 3 ? 32'h0 : $urandom & msk(s);
            @(posedge sys_clk);
            misc_in <= '{1'b1, s, d, 1'b1, 1'b1, 1'b1, n[2]};
            fl[3:0] = {d[s == CRF_SZ_BYTE ? 7 : s == CRF_SZ_WORD ? 15 : 31],
                d == 32'h0, 1'b0, n[2]};
            @(posedge sys_clk);
            misc_in.en <= 1'b0;
            #1;
            chk(condition_code_flags, fl, "logic flags");
        end
        fop(CRF_FOP_LOAD, 8'h00);
        @(posedge sys_clk);
        exc_start <= 1'b1;
        fl[7] = 1'b1;
        @(posedge sys_clk);
        exc_start <= 1'b0;
        #1;
        chk(condition_code_flags, fl, "exception mask");
        done("flag sources");
        for (k = 0; k < 32; k++) begin
            fop(CRF_FOP_LOAD, {k[0], k[1], 6'($urandom)});
            @(posedge sys_clk);
            use_umask <= k[2];
            nmi_req <= k[3];
            irq_req <= k[4];
            repeat (2) @(posedge sys_clk);
            #1;
            md = k[3] | k[4] & !(k[0] | k[2] & k[1]);
            chk(irq_accept, md, "accept");
        end
        done("interrupt masking");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire

/* verilog/crf_core.sv */
// CPU architectural state: general registers, program counter, flags.
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.svh"
module crf_core (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic mode_1m,
    input wire logic [23:0] reset_vector,
    input wire logic vector_valid,
    input wire crf_pkg::crf_wr_t reg_wr,
    input wire logic [2:0] rd_idx,
    input wire crf_pkg::crf_size_t rd_size,
    input wire crf_pkg::crf_part_t rd_part,
    input wire logic sp_wr_en,
    input wire logic [31:0] sp_wr_data,
    input wire logic pc_wr_en,
    input wire logic [23:0] pc_wr_data,
    input wire logic [23:0] ea_in,
    input wire crf_pkg::crf_fop_t flags_op,
    input wire logic [7:0] flags_imm,
    input wire crf_pkg::crf_alu_t alu_in,
    input wire crf_pkg::crf_misc_t misc_in,
    input wire logic exc_start,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic use_umask,
    output logic [31:0] rd_data,
    output logic [31:0] sp_out,
    output logic [23:0] fetch_addr,
    output logic [23:0] pc_out,
    output logic [23:0] ea_out,
    output logic [7:0] condition_code_flags,
    output logic irq_accept,
    output logic ready
);
    import crf_pkg::*;
    localparam int NREG = 8;
    if (NREG != 8) begin : g_bad_nreg
        $error("crf_core serves eight registers only");
    end

    ////////////////////////////////////////////////////////////////////////
    // General registers, left uninitialised by reset on purpose.
    logic [31:0] full_word_reg [NREG];
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            wire logic hit = reg_wr.en && reg_wr.idx == gi[2:0];
            wire logic sp_hit = sp_wr_en && gi[2:0] == `CRF_SP_INDEX;
            wire logic [15:0] old_low = full_word_reg[gi][15:0];
            wire logic [7:0] new_top = reg_wr.data[7:0];
            wire logic [31:0] merged =
                (reg_wr.size == CRF_SZ_LONG) ? reg_wr.data :
                (reg_wr.size == CRF_SZ_WORD) ?
                ((reg_wr.part == CRF_PART_EXT) ?
                    {reg_wr.data[15:0], old_low} :
                    {full_word_reg[gi][31:16], reg_wr.data[15:0]}) :
                ((reg_wr.part == CRF_PART_TOP) ?
                    {full_word_reg[gi][31:16], new_top, old_low[7:0]} :
                    {full_word_reg[gi][31:8], reg_wr.data[7:0]});
            // Register writes win over implicit stack pointer updates.
            always_ff @(posedge sys_clk) begin
                if (hit) begin
                    full_word_reg[gi] <= merged;
                end else if (sp_hit) begin
                    full_word_reg[gi] <= sp_wr_data;
                end
            end
        end
    endgenerate

    wire logic [31:0] rd_word = full_word_reg[rd_idx];
    wire logic [31:0] rd_view =
        (rd_size == CRF_SZ_LONG) ? rd_word :
        (rd_size == CRF_SZ_WORD) ?
        ((rd_part == CRF_PART_EXT) ? {16'h0000, rd_word[31:16]} :
            {16'h0000, rd_word[15:0]}) :
        ((rd_part == CRF_PART_TOP) ? {24'h000000, rd_word[15:8]} :
            {24'h000000, rd_word[7:0]});

    always_ff @(posedge sys_clk) begin
        rd_data <= rd_view;
        sp_out <= full_word_reg[`CRF_SP_INDEX];
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencing and program counter.
    crf_state_t state_q, state_d;
    logic [23:0] pc_q;
    always_comb begin
        state_d = state_q;
        case (state_q)
            CRF_ST_RESET: state_d = CRF_ST_VECTOR;
            CRF_ST_VECTOR: if (vector_valid) state_d = CRF_ST_RUN;
            CRF_ST_RUN: state_d = CRF_ST_RUN;
            default: state_d = CRF_ST_RESET;
        endcase
    end
    wire logic load_vec = state_q == CRF_ST_VECTOR && vector_valid;
    // The 16M mode keeps all 24 address bits and mode_1m masks them to 20; no 16-bit PC path.
    wire logic [23:0] addr_mask =
        mode_1m ? `CRF_ADDR_1M_MASK : `CRF_ADDR_16M_MASK;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= CRF_ST_RESET;
            pc_q <= 24'h000000;
        end else begin
            state_q <= state_d;
            if (load_vec) pc_q <= reset_vector;
            else if (pc_wr_en && state_q == CRF_ST_RUN) pc_q <= pc_wr_data;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_out <= 24'h000000;
            fetch_addr <= 24'h000000;
            ea_out <= 24'h000000;
            ready <= 1'b0;
        end else begin
            pc_out <= pc_q;
            fetch_addr <= pc_q & `CRF_PC_ALIGN_MASK & addr_mask;
            ea_out <= ea_in & addr_mask;
            ready <= state_q == CRF_ST_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic flag evaluation at the operand size.
    wire logic [32:0] sum = alu_in.sub ?
        {1'b0, alu_in.a} - {1'b0, alu_in.b} :
        {1'b0, alu_in.a} + {1'b0, alu_in.b};
    wire logic [31:0] res = sum[31:0];
    wire logic [31:0] cx = alu_in.a ^ alu_in.b ^ res;
    wire logic [4:0] hc_pos = (alu_in.size == CRF_SZ_BYTE) ? `CRF_HC_BYTE :
        (alu_in.size == CRF_SZ_WORD) ? `CRF_HC_WORD : `CRF_HC_LONG;
    wire logic [4:0] msb_pos = (alu_in.size == CRF_SZ_BYTE) ? `CRF_MSB_BYTE :
        (alu_in.size == CRF_SZ_WORD) ? `CRF_MSB_WORD : `CRF_MSB_LONG;
    wire logic [4:0] cout_pos = msb_pos + 5'd1;
    wire logic half_c = cx[hc_pos + 5'd1];
    wire logic carry_c = (alu_in.size == CRF_SZ_LONG) ? sum[32] :
        cx[cout_pos];
    wire logic sa = alu_in.a[msb_pos];
    wire logic sb = alu_in.b[msb_pos] ^ alu_in.sub;
    wire logic sr = res[msb_pos];
    wire logic ovf_c = (sa == sb) && (sr != sa);
    wire logic [31:0] size_mask = (alu_in.size == CRF_SZ_BYTE) ?
        32'h000000ff : (alu_in.size == CRF_SZ_WORD) ? 32'h0000ffff :
        32'hffffffff;
    wire logic zero_c = (res & size_mask) == 32'h00000000;
    wire logic [4:0] mmsb = (misc_in.size == CRF_SZ_BYTE) ? `CRF_MSB_BYTE :
        (misc_in.size == CRF_SZ_WORD) ? `CRF_MSB_WORD : `CRF_MSB_LONG;
    wire logic [31:0] mmask = (misc_in.size == CRF_SZ_BYTE) ?
        32'h000000ff : (misc_in.size == CRF_SZ_WORD) ? 32'h0000ffff :
        32'hffffffff;

    ////////////////////////////////////////////////////////////////////////
    // Flags register; only the mask bit has a reset value.
    logic mask_q;
    logic [6:0] low_flags_q;
    logic [7:0] flags_d;
    wire logic [7:0] flags_q = {mask_q, low_flags_q};
    always_comb begin
        flags_d = flags_q;
        case (flags_op)
            CRF_FOP_LOAD: flags_d = flags_imm;
            CRF_FOP_AND: flags_d = flags_q & flags_imm;
            CRF_FOP_OR: flags_d = flags_q | flags_imm;
            CRF_FOP_XOR: flags_d = flags_q ^ flags_imm;
            default: flags_d = flags_q;
        endcase
        // Flags without an update enable are left as they were.
        if (alu_in.arith) begin
            if (alu_in.upd_half) flags_d[`CRF_BIT_HALF] = half_c;
            if (alu_in.upd_neg) flags_d[`CRF_BIT_NEG] = sr;
            if (alu_in.upd_zero) flags_d[`CRF_BIT_ZERO] = zero_c;
            if (alu_in.upd_ovf) flags_d[`CRF_BIT_OVF] = ovf_c;
            if (alu_in.upd_carry) flags_d[`CRF_BIT_CARRY] = carry_c;
        end
        if (misc_in.en) begin
            if (misc_in.upd_nz) begin
                flags_d[`CRF_BIT_NEG] = misc_in.res[mmsb];
                flags_d[`CRF_BIT_ZERO] =
                    (misc_in.res & mmask) == 32'h00000000;
            end
            if (misc_in.clr_v) flags_d[`CRF_BIT_OVF] = 1'b0;
            // Shift-out bit or bit-accumulator result.
            if (misc_in.upd_carry) flags_d[`CRF_BIT_CARRY] = misc_in.carry_val;
        end
        if (exc_start || state_q != CRF_ST_RUN)
            flags_d[`CRF_BIT_MASK] = 1'b1;
    end
    // Only the mask bit of flags_q is reset, the others keep undefined contents; the condition_code_flags copy is reset to CRF_FLAGS_RESET.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) mask_q <= 1'b1;
        else mask_q <= flags_d[`CRF_BIT_MASK];
    end
    always_ff @(posedge sys_clk) begin
        low_flags_q <= flags_d[6:0];
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) condition_code_flags <= `CRF_FLAGS_RESET;
        else condition_code_flags <= flags_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt gating: NMI bypasses both masks.
    wire logic spare_mask_bit = flags_q[`CRF_BIT_UMASK];
    wire logic masked = flags_q[`CRF_BIT_MASK] ||
        (use_umask && spare_mask_bit);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) irq_accept <= 1'b0;
        else irq_accept <= nmi_req || (irq_req && !masked);
    end

    ////////////////////////////////////////////////////////////////////////
    a_mask_blocks: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (flags_q[`CRF_BIT_MASK] && !nmi_req) |=> !irq_accept)
        else $error("masked interrupt accepted");
    a_nmi_always: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        nmi_req |=> irq_accept)
        else $error("nmi not accepted");
    a_umask_blocks: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (use_umask && spare_mask_bit && !nmi_req) |=> !irq_accept)
        else $error("user mask did not block interrupt");
    a_exc_sets_mask: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        exc_start |=> flags_q[`CRF_BIT_MASK])
        else $error("exception did not set mask");
    a_mask_idle: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        state_q != CRF_ST_RUN |-> flags_q[`CRF_BIT_MASK])
        else $error("mask clear before run");
    a_fetch_even: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 fetch_addr ==
            ($past(pc_q) & `CRF_PC_ALIGN_MASK & $past(addr_mask)))
        else $error("fetch address misaligned");
    a_trunc_1m: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        mode_1m |=> ea_out[23:20] == 4'h0)
        else $error("upper address bits not dropped");
    a_vec_load: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        load_vec |=> (pc_q == $past(reset_vector)) ##1 ready)
        else $error("reset vector not loaded");
    a_pc_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state_q != CRF_ST_RUN && !load_vec) |=> $stable(pc_q))
        else $error("pc changed before reset vector");
    a_xor_flags: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (flags_op == CRF_FOP_XOR && !alu_in.arith && !misc_in.en &&
         !exc_start && state_q == CRF_ST_RUN)
        |=> flags_q == ($past(flags_q) ^ $past(flags_imm)))
        else $error("flag xor wrong");
    a_load_flags: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (flags_op == CRF_FOP_LOAD && !alu_in.arith && !misc_in.en &&
         !exc_start && state_q == CRF_ST_RUN)
        |=> flags_q == $past(flags_imm))
        else $error("flag load wrong");
    a_zero_flag: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (alu_in.arith && alu_in.upd_zero && flags_op == CRF_FOP_NONE &&
         !misc_in.en)
        |=> flags_q[`CRF_BIT_ZERO] == $past(zero_c))
        else $error("zero flag wrong");
    // A separate nibble sum keeps this check apart from the flag datapath.
    wire logic [4:0] nib_sum = {1'b0, alu_in.a[3:0]} + {1'b0, alu_in.b[3:0]};
    a_half_byte: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (alu_in.arith && !alu_in.sub && alu_in.size == CRF_SZ_BYTE &&
         alu_in.upd_half && flags_op == CRF_FOP_NONE && !misc_in.en)
        |=> flags_q[`CRF_BIT_HALF] == $past(nib_sum[4]))
        else $error("byte half carry wrong");
    a_carry_misc: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (misc_in.en && misc_in.upd_carry)
        |=> flags_q[`CRF_BIT_CARRY] == $past(misc_in.carry_val))
        else $error("carry accumulator wrong");
    a_byte_keep: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (reg_wr.en && reg_wr.size == CRF_SZ_BYTE &&
         reg_wr.part == CRF_PART_BOTTOM)
        |=> full_word_reg[$past(reg_wr.idx)][31:8] ==
            $past(full_word_reg[reg_wr.idx][31:8]))
        else $error("byte write disturbed other bits");
    a_sp_write: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (sp_wr_en && !(reg_wr.en && reg_wr.idx == `CRF_SP_INDEX))
        |=> full_word_reg[`CRF_SP_INDEX] == $past(sp_wr_data)
        ##1 sp_out == $past(sp_wr_data, 2))
        else $error("stack pointer write lost");
endmodule : crf_core
`default_nettype wire
